// *** design/mac_params.svh ***
// Constants for the micromirror array load controller
`ifndef MAC_PARAMS_SVH
`define MAC_PARAMS_SVH
`define MAC_CLK_KHZ   125000
`define MAC_REF_MHZ   50
`define MAC_INIT_MS   220
`define MAC_PARK_US   300
`define MAC_STRB_NS   40
`define MAC_LEVEL_NS  400
`define MAC_SPI_HALF  4
`define MAC_HB_EDGES  25000000
`define MAC_REG_CTRL   8'h00
`define MAC_REG_STATUS 8'h04
`define MAC_REG_TX     8'h08
`define MAC_REG_RX     8'h0C
`define MAC_REG_ROW    8'h10
`define MAC_CTRL_RST   1'h1
`define MAC_INIT_BYTE  8'h5A
`define MAC_KIND_A     4'h1
`define MAC_KIND_B     4'h2
`define MAC_SEL_BIAS   2'h1
`define MAC_SEL_OFFSET 2'h2
`define MAC_SEL_KICK   2'h3
`define MAC_CNT_ALL    2'h3
`define MAC_RESP_OK    2'h0
`define MAC_RESP_ERR   2'h2
`endif

// *** design/mac_pkg.sv ***
// Types for the micromirror array load controller
package mac_pkg;
    typedef enum logic [1:0] {
        I_SEND = 2'b00,
        I_WAIT = 2'b01,
        I_RUN  = 2'b11
    } mac_init_t;

    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_KICK = 2'b01,
        P_BIAS = 2'b11,
        P_PARK = 2'b10
    } mac_pulse_t;

    typedef struct packed {
        logic [28:0] m1;
        logic [28:0] m2;
        logic [71:0] l1;
        logic [71:0] l2;
        logic [3:0]  lclk3;
        logic        ref3;
        logic [24:0] hb_cnt;
        logic        hb;
        mac_init_t   ist;
        logic [24:0] icnt;
        logic        iact;
        logic        ok;
        logic        bad;
        logic [3:0]  kind;
        mac_pulse_t  pst;
        logic [15:0] pcnt;
        logic        strb;
        logic [1:0]  cnt_sel;
        logic [1:0]  lvl;
        logic [3:0]  grp;
        logic        ract;
        logic        parked;
        logic        go3;
        logic [63:0] dout;
        logic [3:0]  dclk;
        logic [3:0]  sctrl;
        logic        sel_n;
        logic        sck;
        logic        si;
        logic        busy;
        logic [7:0]  sh;
        logic [7:0]  rx;
        logic [3:0]  bits;
        logic [2:0]  div;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        run;
        logic [12:0] row;
    } mac_state_t;
endpackage

// *** design/mac_top.sv ***
// Micromirror array load controller: data forwarding, pulse driver control, init
`timescale 1ns/10ps
`include "mac_params.svh"
module mac_top
    import mac_pkg::*;
#(
    parameter int unsigned INIT_CYC = `MAC_INIT_MS * `MAC_CLK_KHZ,
    parameter int unsigned PARK_CYC = `MAC_PARK_US * `MAC_CLK_KHZ / 1000,
    parameter int unsigned HB_EDGES = `MAC_HB_EDGES
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        async_reset_n,
    input  wire logic        ref_clock_in,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // User data and commands
    input  wire logic [63:0] user_data_bus,
    input  wire logic [3:0]  user_data_clock,
    input  wire logic [3:0]  user_data_valid,
    input  wire logic [1:0]  row_mode_ctrl,
    input  wire logic [10:0] row_addr_ptr,
    input  wire logic [3:0]  block_addr_ptr,
    input  wire logic [1:0]  block_cmd_mode,
    input  wire logic        block_cmd_go,
    input  wire logic        mirror_park_request,
    input  wire logic [3:0]  array_id_in,
    // Status to user
    output logic [3:0]       array_kind_out,
    output logic             reset_active_out,
    output logic             init_active_out,
    output logic             heartbeat_out,
    output logic             init_done_out,
    // Array side
    output logic [63:0]      array_data_bus,
    output logic [3:0]       array_data_clock,
    output logic [3:0]       array_serial_ctrl,
    // Pulse driver
    output logic             driver_port_select_n,
    output logic             port_serial_clock,
    output logic             port_serial_in,
    input  wire logic        port_serial_out,
    input  wire logic        driver_irq,
    output logic             level_strobe,
    output logic [1:0]       out_count_sel,
    output logic [1:0]       level_sel,
    output logic [3:0]       group_addr
);
    localparam int unsigned STRB_CYC = (`MAC_STRB_NS * `MAC_CLK_KHZ + 999999) / 1000000;
    localparam int unsigned LVL_CYC  = (`MAC_LEVEL_NS * `MAC_CLK_KHZ + 999999) / 1000000;

    mac_state_t q;
    mac_state_t d;
    logic [63:0] lane_dout;
    logic [3:0]  lane_fwd;
    logic        go_edge;
    logic        ref_edge;
    logic        rst;

    // Pin sampling reused below: [0] reset pin, [1] ref clk, [2] park, [3] go
    // [4] serial return, [5] irq, [9:6] id, [11:10] mode, [15:12] block, [28:16] row
    assign rst      = !aresetn || !q.m2[0];
    assign go_edge  = q.m2[3] && !q.go3;
    assign ref_edge = q.m2[1] && !q.ref3;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_lane
            // Each bus sampled on both edges of its own clock
            assign lane_fwd[i] = (q.l2[i] ^ q.lclk3[i]) && q.l2[4 + i] && q.ok && q.run
                                 && !q.parked;
            assign lane_dout[16*i +: 16] = lane_fwd[i] ? q.l2[8 + 16*i +: 16]
                                                       : q.dout[16*i +: 16];
        end
    endgenerate

    always_comb begin
        d = q;
        d.m1    = {row_addr_ptr, row_mode_ctrl, block_addr_ptr, block_cmd_mode, array_id_in,
                   driver_irq, port_serial_out, block_cmd_go, mirror_park_request,
                   ref_clock_in, async_reset_n};
        d.m2    = q.m1;
        d.l1    = {user_data_bus, user_data_valid, user_data_clock};
        d.l2    = q.l1;
        d.lclk3 = q.l2[3:0];
        d.ref3  = q.m2[1];
        d.go3   = q.m2[3];

        // Heartbeat counts reference edges so it also proves that clock runs
        if (ref_edge) begin
            if (q.hb_cnt == 25'(HB_EDGES - 1)) begin
                d.hb_cnt = '0;
                d.hb     = !q.hb;
            end else begin
                d.hb_cnt = q.hb_cnt + 25'h1;
            end
        end

        // Forwarding toward the array
        d.dout  = lane_dout;
        d.dclk  = q.dclk ^ lane_fwd;
        d.sctrl = lane_fwd;

        // Serial port shifter, mode 0, MSB first
        if (q.busy) begin
            if (q.div == 3'(`MAC_SPI_HALF - 1)) begin
                d.div = '0;
                if (!q.sck) begin
                    d.sck  = 1'b1;
                    d.rx   = {q.rx[6:0], q.m2[4]};
                    d.bits = q.bits + 4'h1;
                end else begin
                    d.sck = 1'b0;
                    if (q.bits == 4'h8) begin
                        d.busy  = 1'b0;
                        d.sel_n = 1'b1;
                    end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.si = q.sh[6];
                    end
                end
            end else begin
                d.div = q.div + 3'h1;
            end
        end

        // Initialization: program driver, wait, then check the array
        case (q.ist)
            I_SEND: begin
                d.busy  = 1'b1;
                d.sel_n = 1'b0;
                d.sh    = `MAC_INIT_BYTE;
                d.si    = 1'(`MAC_INIT_BYTE >> 7);
                d.bits  = '0;
                d.div   = '0;
                d.ist   = I_WAIT;
            end
            I_WAIT: begin
                if (q.icnt == 25'(INIT_CYC - 1) && !q.busy) begin
                    d.ist  = I_RUN;
                    d.iact = 1'b0;
                    // Unknown ids keep the array dark for good
                    if (q.m2[9:6] == `MAC_KIND_A || q.m2[9:6] == `MAC_KIND_B) begin
                        d.kind = q.m2[9:6];
                        d.ok   = 1'b1;
                    end else begin
                        d.bad = 1'b1;
                    end
                end else if (q.icnt != 25'(INIT_CYC - 1)) begin
                    d.icnt = q.icnt + 25'h1;
                end
            end
            I_RUN: begin
                d.ist = I_RUN;
            end
            default: d.ist = I_SEND;
        endcase

        // Pulse waveform: kick then bias for a command, offset alone for park, each strobed once
        case (q.pst)
            P_IDLE: begin
                if (q.m2[2] && q.ok) begin
                    d.pst     = P_PARK;
                    d.cnt_sel = `MAC_CNT_ALL;
                    d.lvl     = `MAC_SEL_OFFSET;
                    d.grp     = '0;
                    d.pcnt    = '0;
                    d.ract    = 1'b1;
                end else if (go_edge && q.ok) begin
                    // Row pointer is sampled with the command so data is set up first
                    d.row     = q.m2[28:16];
                    d.pst     = P_KICK;
                    d.cnt_sel = q.m2[11:10];
                    d.lvl     = `MAC_SEL_KICK;
                    d.pcnt    = '0;
                    d.ract    = 1'b1;
                    case (q.m2[11:10])
                        2'h0:    d.grp = q.m2[15:12];
                        2'h1:    d.grp = {q.m2[15:13], 1'b0};
                        2'h2:    d.grp = {q.m2[15:14], 2'h0};
                        default: d.grp = 4'h0;
                    endcase
                end
            end
            P_KICK, P_BIAS: begin
                if (q.pcnt == 16'(LVL_CYC - 1)) begin
                    d.pcnt = '0;
                    if (q.pst == P_KICK) begin
                        d.pst = P_BIAS;
                        d.lvl = `MAC_SEL_BIAS;
                    end else begin
                        d.pst  = P_IDLE;
                        d.ract = 1'b0;
                    end
                end else begin
                    d.pcnt = q.pcnt + 16'h1;
                end
            end
            P_PARK: begin
                // Park holds until the request drops; data stops passing only once the park count ends and parked is set
                if (!q.m2[2]) begin
                    d.pst    = P_IDLE;
                    d.parked = 1'b0;
                    d.ract   = 1'b0;
                end else if (q.pcnt == 16'(PARK_CYC - 1)) begin
                    d.parked = 1'b1;
                    d.ract   = 1'b0;
                end else begin
                    d.pcnt = q.pcnt + 16'h1;
                end
            end
            default: d.pst = P_IDLE;
        endcase
        d.strb = (d.pst != P_IDLE) && !d.parked && (d.pcnt < 16'(STRB_CYC));

        // Register writes: address and data taken together
        if (q.awready) begin
            d.awready = 1'b0;
            d.wready  = 1'b0;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (!q.bvalid && !q.awready && s_axi_awvalid && s_axi_wvalid) begin
            d.awready = 1'b1;
            d.wready  = 1'b1;
            d.bvalid  = 1'b1;
            d.bresp   = `MAC_RESP_OK;
            case (s_axi_awaddr)
                `MAC_REG_CTRL: if (s_axi_wstrb[0]) d.run = s_axi_wdata[0];
                `MAC_REG_TX: begin
                    // Dropped while busy or before init ends
                    if (s_axi_wstrb[0] && !q.busy && q.ist == I_RUN) begin
                        d.busy  = 1'b1;
                        d.sel_n = 1'b0;
                        d.sh    = s_axi_wdata[7:0];
                        d.si    = s_axi_wdata[7];
                        d.bits  = '0;
                        d.div   = '0;
                    end
                end
                `MAC_REG_STATUS, `MAC_REG_RX, `MAC_REG_ROW: d.bresp = `MAC_RESP_OK;
                default: d.bresp = `MAC_RESP_ERR;
            endcase
        end

        // Register reads
        if (q.arready) begin
            d.arready = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (!q.rvalid && !q.arready && s_axi_arvalid) begin
            d.arready = 1'b1;
            d.rvalid  = 1'b1;
            d.rresp   = `MAC_RESP_OK;
            case (s_axi_araddr)
                `MAC_REG_CTRL:   d.rdata = {31'h0, q.run};
                `MAC_REG_STATUS: d.rdata = {20'h0, q.kind, 2'h0, q.m2[5], q.busy,
                                            q.bad, q.parked, q.ract, q.iact};
                `MAC_REG_RX:     d.rdata = {24'h0, q.rx};
                `MAC_REG_ROW:    d.rdata = {19'h0, q.row};
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = `MAC_RESP_ERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (rst) begin
            q       <= '0;
            q.m1    <= d.m1;
            q.m2    <= d.m2;
            q.iact  <= 1'b1;
            q.sel_n <= 1'b1;
            q.run   <= `MAC_CTRL_RST;
            q.ist   <= I_SEND;
            q.pst   <= P_IDLE;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready        = q.awready;
    assign s_axi_wready         = q.wready;
    assign s_axi_bvalid         = q.bvalid;
    assign s_axi_bresp          = q.bresp;
    assign s_axi_arready        = q.arready;
    assign s_axi_rvalid         = q.rvalid;
    assign s_axi_rdata          = q.rdata;
    assign s_axi_rresp          = q.rresp;
    assign array_kind_out       = q.kind;
    assign reset_active_out     = q.ract;
    assign init_active_out      = q.iact;
    assign heartbeat_out        = q.hb;
    assign init_done_out        = q.ok;
    assign array_data_bus       = q.dout;
    assign array_data_clock     = q.dclk;
    assign array_serial_ctrl    = q.sctrl;
    assign driver_port_select_n = q.sel_n;
    assign port_serial_clock    = q.sck;
    assign port_serial_in       = q.si;
    assign level_strobe         = q.strb;
    assign out_count_sel        = q.cnt_sel;
    assign level_sel            = q.lvl;
    assign group_addr           = q.grp;
endmodule // mac_top

// *** verification/mac_top_assertions.sv ***
// Port checker for the mirror array load controller, bound to mac_top
`timescale 1ns/10ps
`include "mac_params.svh"
module mac_chk #(
    parameter int unsigned INIT_CYC = 200
) (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // User commands and status
    input wire logic       block_cmd_go,
    input wire logic       mirror_park_request,
    input wire logic [3:0] array_kind_out,
    input wire logic       reset_active_out,
    input wire logic       init_active_out,
    input wire logic       init_done_out,
    // Pulse driver
    input wire logic       driver_port_select_n,
    input wire logic       port_serial_clock,
    input wire logic       level_strobe,
    input wire logic [1:0] out_count_sel,
    input wire logic [1:0] level_sel,
    input wire logic [3:0] group_addr
);
    logic [31:0] icnt_q;
    logic [31:0] icnt_d;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Counter, not a long repetition
    always_comb icnt_d = init_active_out ? icnt_q + 32'h1 : 32'h0;
    always_ff @(posedge aclk) icnt_q <= aresetn ? icnt_d : 32'h0;

    a_sck_in_frame: assert property ($rose(port_serial_clock) |-> !driver_port_select_n)
        else $error("serial clock outside select");
    a_frame_held: assert property ($fell(driver_port_select_n) |=> !driver_port_select_n [*8])
        else $error("select dropped mid byte");
    a_strobe_width: assert property ($rose(level_strobe) |-> level_strobe [*5] ##1 !level_strobe)
        else $error("strobe width wrong");
    a_strobe_busy: assert property ($rose(level_strobe) |-> ##[0:1] reset_active_out)
        else $error("strobe without reset active");
    a_level_held: assert property ($rose(level_strobe) |=>
        ($stable(level_sel) && $stable(group_addr)) [*4]) else $error("level moved under strobe");
    a_kick_bias: assert property ($rose(level_strobe) && level_sel == `MAC_SEL_KICK |->
        ##[45:55] ($rose(level_strobe) && level_sel == `MAC_SEL_BIAS)) else $error("no bias step");
    a_park_all: assert property ($rose(level_strobe) && level_sel == `MAC_SEL_OFFSET |->
        out_count_sel == `MAC_CNT_ALL && mirror_park_request) else $error("park not global");
    a_global_grp: assert property ($rose(level_strobe) && out_count_sel == `MAC_CNT_ALL |->
        group_addr == 4'h0) else $error("global group not zero");
    a_go_start: assert property ($rose(block_cmd_go) && init_done_out && !reset_active_out &&
        !mirror_park_request |-> ##[1:8] reset_active_out) else $error("command not started");
    a_kind_known: assert property (init_done_out |-> array_kind_out != 4'h0)
        else $error("done with unknown array");
    a_init_span: assert property ($fell(init_active_out) |-> icnt_q >= INIT_CYC)
        else $error("init ended early");

    c_kick: cover property ($rose(level_strobe) && level_sel == `MAC_SEL_KICK);
    c_park: cover property ($rose(level_strobe) && level_sel == `MAC_SEL_OFFSET);
    c_init: cover property ($fell(init_active_out) && init_done_out);
endmodule // mac_chk

bind mac_top mac_chk #(.INIT_CYC(INIT_CYC)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .block_cmd_go(block_cmd_go),
    .mirror_park_request(mirror_park_request), .array_kind_out(array_kind_out),
    .reset_active_out(reset_active_out), .init_active_out(init_active_out),
    .init_done_out(init_done_out), .driver_port_select_n(driver_port_select_n),
    .port_serial_clock(port_serial_clock), .level_strobe(level_strobe),
    .out_count_sel(out_count_sel), .level_sel(level_sel), .group_addr(group_addr)
);

// *** verification/mac_user_model.sv ***
// User-side source model: four DDR lanes, each with its own clock and valid
`timescale 1ns/10ps
module mac_user_model (
    // User data lanes
    output logic [63:0] user_data_bus,
    output logic [3:0]  user_data_clock,
    output logic [3:0]  user_data_valid
);
    initial begin
        user_data_bus = 64'h0;
        user_data_clock = 4'h0;
        user_data_valid = 4'h0;
    end
    // Mode 0 valid frame, 1 valid held low, 2 training pattern
    task automatic send(input int n, input logic [15:0] base, input int mode);
        #3.3;
        user_data_valid = (mode == 0) ? 4'hF : 4'h0;
        #40;
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 4; i++)
                user_data_bus[16*i+:16] = base + 16'(k) + 16'(16'h1111 * i);
            user_data_clock = ~user_data_clock;
            if (mode == 2) user_data_valid = ~user_data_valid;
            #40;
        end
        user_data_valid = 4'h0;
        user_data_bus = ~user_data_bus;
    endtask
endmodule // mac_user_model

// *** verification/micromirror_array_load_control_bench.sv ***
// Self-checking bench for the mirror array load controller
`timescale 1ns/10ps
`include "mac_params.svh"
module micromirror_array_load_control_bench;
    logic        aclk = 1'b0, aresetn = 1'b0, async_reset_n = 1'b1, ref_clock_in = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, out_count_sel, level_sel;
    wire  [63:0] user_data_bus;
    wire  [3:0]  user_data_clock, user_data_valid;
    logic [63:0] array_data_bus;
    logic [3:0]  array_data_clock, array_kind_out, group_addr, array_serial_ctrl;
    logic [1:0]  row_mode_ctrl = 2'h0, block_cmd_mode = 2'h0;
    logic [10:0] row_addr_ptr = 11'h0;
    logic [3:0]  block_addr_ptr = 4'h0, array_id_in = 4'h1;
    logic        block_cmd_go = 1'b0, mirror_park_request = 1'b0, driver_irq = 1'b0;
    logic        reset_active_out, init_active_out, heartbeat_out, init_done_out;
    logic        driver_port_select_n, port_serial_clock, port_serial_in, level_strobe;
    wire         port_serial_out;
    logic [31:0] seed_q = 32'hAFCB;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [7:0]  sq[$], tq[$], rsp = 8'h00, sr = 8'h00, sh = 8'h00;
    logic [15:0] lq[4][$];
    logic [3:0]  dclk_p = 4'h0;
    logic        strb_p = 1'b0, sck_p = 1'b0, tgl = 1'b0;
    int          miscompares = 0, tests_run = 0, nb = 0;

    mac_top #(.INIT_CYC(200), .PARK_CYC(50), .HB_EDGES(4)) dut_u (
        .aclk, .aresetn, .async_reset_n, .ref_clock_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .user_data_bus, .user_data_clock, .user_data_valid, .row_mode_ctrl, .row_addr_ptr,
        .block_addr_ptr, .block_cmd_mode, .block_cmd_go, .mirror_park_request, .array_id_in,
        .array_kind_out, .reset_active_out, .init_active_out, .heartbeat_out, .init_done_out,
        .array_data_bus, .array_data_clock, .array_serial_ctrl, .driver_port_select_n,
        .port_serial_clock, .port_serial_in, .port_serial_out, .driver_irq, .level_strobe,
        .out_count_sel, .level_sel, .group_addr
    );
    mac_user_model user_u (.user_data_bus, .user_data_clock, .user_data_valid);

    always #4 aclk = ~aclk;
    always #10 ref_clock_in = ~ref_clock_in;
    function automatic logic [31:0] rnd();
        seed_q = seed_q ^ (seed_q << 13);
        seed_q = seed_q ^ (seed_q >> 17);
        seed_q = seed_q ^ (seed_q << 5);
        return seed_q;
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bq.push_back(e);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic finish_test();
        if (rq.size() + bq.size() + sq.size() + tq.size() + lq[0].size() > 0) miscompares++;
        if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Pulse driver serial answer; idle line toggles so no stale bit is seen
    always @(posedge aclk) begin
        sck_p <= port_serial_clock;
        tgl <= ~tgl;
        if (driver_port_select_n) sr <= rsp;
        else if (sck_p && !port_serial_clock) sr <= {sr[6:0], 1'b0};
    end
    assign port_serial_out = driver_port_select_n ? tgl : sr[7];

    always @(negedge driver_port_select_n) nb = 0;
    always @(posedge port_serial_clock) if (!driver_port_select_n) begin
        sh = {sh[6:0], port_serial_in};
        nb++;
    end
    always @(posedge driver_port_select_n) if (nb == 8) chk(40'(sh), 40'(tq.pop_front()), "tx");
    always @(posedge aclk) begin
        dclk_p <= array_data_clock;
        strb_p <= level_strobe;
        if (s_axi_rvalid && s_axi_rready)
            chk(40'({s_axi_rresp, s_axi_rdata}), 40'(rq.pop_front()), "read");
        if (s_axi_bvalid && s_axi_bready) chk(40'(s_axi_bresp), 40'(bq.pop_front()), "bresp");
        if (level_strobe && !strb_p)
            chk(40'({level_sel, out_count_sel, group_addr}), 40'(sq.pop_front()), "strobe");
        for (int i = 0; i < 4; i++)
            if (aresetn && array_data_clock[i] !== dclk_p[i])
                chk(40'({array_serial_ctrl[i], array_data_bus[16*i+:16]}),
                    40'({1'b1, lq[i].pop_front()}), "lane");
    end

    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    initial begin
        logic [31:0] r;
        logic [3:0]  g;
        logic        p;
        int          n;
        r = rnd();
        array_id_in <= {3'h0, r[0]} + 4'h1;
        driver_irq <= r[1];
        rsp = r[15:8];
        tq.push_back(`MAC_INIT_BYTE);
        repeat (8) @(posedge aclk);
        chk(40'({driver_port_select_n, init_active_out, reset_active_out}), 40'h6, "rst");
        aresetn <= 1'b1;
        user_u.send(16, 16'h0F0F, 2);
        while (init_active_out !== 1'b0) @(posedge aclk);
        @(posedge aclk);
        chk(40'({init_done_out, array_kind_out}), 40'({1'b1, array_id_in}), "kind");
        rd(`MAC_REG_CTRL, 34'h1);
        rd(`MAC_REG_STATUS, 34'({array_id_in, 2'h0, driver_irq, 5'h0}));
        rd(8'h14, {`MAC_RESP_ERR, 32'h0});
        wr(8'h14, 32'h0, `MAC_RESP_ERR);
        r = rnd();
        rsp = r[7:0];
        tq.push_back(r[15:8]);
        wr(`MAC_REG_TX, {24'h0, r[15:8]}, `MAC_RESP_OK);
        while (driver_port_select_n !== 1'b0) @(posedge aclk);
        while (driver_port_select_n !== 1'b1) @(posedge aclk);
        rd(`MAC_REG_RX, {26'h0, rsp});
        for (int k = 0; k < 8; k++)
            for (int j = 0; j < 4; j++) lq[j].push_back(r[15:0] + 16'(k) + 16'(16'h1111 * j));
        user_u.send(8, r[15:0], 0);
        user_u.send(4, r[31:16], 1);
        wr(`MAC_REG_CTRL, 32'h0, `MAC_RESP_OK);
        user_u.send(4, r[31:16], 0);
        wr(`MAC_REG_CTRL, 32'h1, `MAC_RESP_OK);
        for (int m = 0; m < 4; m++) begin
            r = rnd();
            g = r[3:0] & ((m == 0) ? 4'hF : (m == 1) ? 4'hE : (m == 2) ? 4'hC : 4'h0);
            sq.push_back({`MAC_SEL_KICK, 2'(m), g});
            sq.push_back({`MAC_SEL_BIAS, 2'(m), g});
            block_addr_ptr <= r[3:0];
            block_cmd_mode <= 2'(m);
            row_addr_ptr <= r[14:4];
            row_mode_ctrl <= r[16:15];
            @(posedge aclk);
            block_cmd_go <= 1'b1;
            while (reset_active_out !== 1'b1) @(posedge aclk);
            block_cmd_go <= 1'b0;
            repeat (3) @(posedge aclk);
            // A second command while busy must be dropped
            block_cmd_go <= 1'b1;
            while (reset_active_out !== 1'b0) @(posedge aclk);
            block_cmd_go <= 1'b0;
            rd(`MAC_REG_ROW, 34'({r[14:4], r[16:15]}));
        end
        sq.push_back({`MAC_SEL_OFFSET, `MAC_CNT_ALL, 4'h0});
        mirror_park_request <= 1'b1;
        n = 0;
        while (reset_active_out !== 1'b1) @(posedge aclk);
        while (reset_active_out === 1'b1) begin
            @(posedge aclk);
            n++;
        end
        chk(40'(n >= 45 && n <= 60), 40'h1, "park span");
        rd(`MAC_REG_STATUS, 34'({array_id_in, 2'h0, driver_irq, 5'h4}));
        mirror_park_request <= 1'b0;
        repeat (5) @(posedge aclk);
        n = 0;
        p = heartbeat_out;
        repeat (200) begin
            @(posedge aclk);
            if (heartbeat_out !== p) n++;
            p = heartbeat_out;
        end
        chk(40'(n >= 19 && n <= 21), 40'h1, "heartbeat");
        array_id_in <= 4'h7;
        async_reset_n <= 1'b0;
        repeat (4) @(posedge aclk);
        async_reset_n <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(40'({init_active_out, init_done_out, reset_active_out}), 40'h4, "pin");
        tq.push_back(`MAC_INIT_BYTE);
        while (init_active_out !== 1'b0) @(posedge aclk);
        @(posedge aclk);
        chk(40'({init_done_out, array_kind_out}), 40'h0, "unknown");
        block_cmd_go <= 1'b1;
        user_u.send(4, r[15:0], 0);
        chk(40'(reset_active_out), 40'h0, "refused");
        finish_test();
    end
endmodule // micromirror_array_load_control_bench
